// [include/pps_regs.svh]
// constants for the panel password, tuning and self-test block
// How it works
// - stored zero password means no protection
// - matching entry clears lock, restores write access
// - mismatch keeps lock and rejects parameter writes
// - nonzero password shows lock mark in level two while still locked
// - leaving programming re-arms the password lock
// - correct code then 0000 disables password
// - tuning select value 2 enters tuning state
// - tuning flashes three unit leds, shows mark
// - tuning guard refuses tuning when it forbids
// - both keys while stopped start self-test
// - step one lights low digits, then high
// - step two adds one indicator per half second
// - step three darkens lcd left to right
// - step four writes and reads every memory cell
// - valid stored data skips the memory step
// - save stores and advances, menu discards
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH

// ****************************************
// values
// ****************************************
`define PPS_PW_NONE      16'h0000
`define PPS_TUNE_SEL     16'h0002
`define PPS_UNITS_ALL    3'h7
`define PPS_UNITS_OFF    3'h0
`define PPS_UNITS_FIRST  3'h1
`define PPS_LCD_COLS     8'h80
`define PPS_MEM_LAST     8'hFF
`define PPS_MEM_PATTERN  8'hA5

// ****************************************
// timing
// ****************************************
`define PPS_CLK_NS       4
`define PPS_STEP_NS      500000000
`define PPS_COL_NS       3000000

`endif

// [include/pps_pkg.sv]
// types shared by the panel block
package pps_pkg;
    typedef enum logic [1:0] {
        PPS_PAR_OTHER,
        PPS_PAR_PASSWORD,
        PPS_PAR_TUNE_SEL
    } pps_param_t;

    typedef enum logic [2:0] {
        PPS_ST_IDLE,
        PPS_ST_DIGIT_LO,
        PPS_ST_DIGIT_HI,
        PPS_ST_UNITS,
        PPS_ST_LCD,
        PPS_ST_MEM_WR,
        PPS_ST_MEM_RD,
        PPS_ST_MEM_CHK
    } pps_st_t;
endpackage : pps_pkg

// [include/pps_key_if.sv]
// debounced panel keys passed from the synchroniser to the panel logic
`timescale 1ns/1ps
`default_nettype none
interface pps_key_if;
    logic menu_escape_key;
    logic halt_clear_key;
    modport src (output menu_escape_key, output halt_clear_key);
    modport dst (input menu_escape_key, input halt_clear_key);
endinterface : pps_key_if
`default_nettype wire

// [hdl/pps_keysync.sv]
// three-stage synchroniser for the two panel key pins
`timescale 1ns/1ps
`default_nettype none
module pps_keysync (
    // clock and reset
    input  wire logic    clk_sys,
    input  wire logic    rst_n,
    // raw key pins, high when pressed
    input  wire logic    menu_escape_key_pin,
    input  wire logic    halt_clear_key_pin,
    // clean keys
    pps_key_if.src       keys
);
    logic [1:0] s1_q, s2_q, s3_q, stable_q;
    logic [1:0] stable_d;

    // a change counts only when the second and third stages agree
    always_comb begin
        stable_d = stable_q;
        for (int i = 0; i < 2; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                stable_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_q     <= 2'h0;
            s2_q     <= 2'h0;
            s3_q     <= 2'h0;
            stable_q <= 2'h0;
        end else begin
            s1_q     <= {halt_clear_key_pin, menu_escape_key_pin};
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            stable_q <= stable_d;
        end
    end

    assign keys.menu_escape_key = stable_q[0];
    assign keys.halt_clear_key  = stable_q[1];
endmodule : pps_keysync
`default_nettype wire

// [hdl/pps_panel.sv]
// panel password gate, tuning entry and four-step self-test
`timescale 1ns/1ps
`default_nettype none
`include "pps_regs.svh"
module pps_panel #(
    parameter logic [31:0] STEP_CYC = `PPS_STEP_NS / `PPS_CLK_NS,
    parameter logic [31:0] COL_CYC  = `PPS_COL_NS / `PPS_CLK_NS
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // key pins
    input  wire logic              menu_escape_key_pin,
    input  wire logic              halt_clear_key_pin,
    // menu edits from the keypad scanner
    input  wire logic              edit_valid,
    input  wire pps_pkg::pps_param_t edit_param,
    input  wire logic [15:0]       edit_value,
    input  wire logic              edit_save,
    input  wire logic              menu_level2,
    input  wire logic              prog_exit,
    // drive state
    input  wire logic              drive_stopped,
    input  wire logic              tuning_guard_param,
    input  wire logic              tune_done,
    input  wire logic              nv_data_valid,
    // keypad nonvolatile memory
    output logic [7:0]             mem_addr_q,
    output logic [7:0]             mem_wdata_q,
    output logic                   mem_we_q,
    output logic                   mem_re_q,
    input  wire logic [7:0]        mem_rdata,
    // parameter store
    output logic                   param_wr_q,
    output logic [15:0]            param_wr_data_q,
    output logic                   param_adv_q,
    output logic                   wr_reject_q,
    // display
    output logic                   lock_mark_q,
    output logic                   tune_mark_q,
    output logic [2:0]             unit_led_q,
    output logic                   digit_lo_q,
    output logic                   digit_hi_q,
    output logic [7:0]             lcd_dark_q,
    output logic                   selftest_busy_q,
    output logic                   selftest_fail_q
);
    import pps_pkg::*;

    pps_key_if keys ();

    pps_keysync u_keysync (
        .clk_sys             (clk_sys),
        .rst_n               (rst_n),
        .menu_escape_key_pin (menu_escape_key_pin),
        .halt_clear_key_pin  (halt_clear_key_pin),
        .keys                (keys)
    );

    // ****************************************
    // password and tuning
    // ****************************************
    logic [15:0] pw_q, pw_d;
    logic        unlock_q, unlock_d;
    logic        tune_q, tune_d;
    logic        blink_q, blink_d;
    logic        param_wr_d, param_adv_d, wr_reject_d, lock_mark_d;
    logic [15:0] param_wr_data_d;
    logic [31:0] blink_cnt_q, blink_cnt_d;
    logic        locked;
    logic        save_ok;
    pps_st_t     st_q;

    assign locked  = (pw_q != `PPS_PW_NONE) && !unlock_q;
    // panel edits are ignored while the self-test owns the display
    assign save_ok = edit_valid && edit_save && (st_q == PPS_ST_IDLE);

    always_comb begin
        pw_d            = pw_q;
        unlock_d        = unlock_q;
        tune_d          = tune_q;
        param_wr_d      = 1'b0;
        param_adv_d     = 1'b0;
        wr_reject_d     = 1'b0;
        param_wr_data_d = param_wr_data_q;
        blink_d         = blink_q;
        blink_cnt_d     = blink_cnt_q + 32'h1;
        if (!tune_q || blink_cnt_q >= STEP_CYC - 32'h1) begin
            blink_cnt_d = 32'h0;
            blink_d     = tune_q ? !blink_q : 1'b0;
        end
        if (save_ok) begin
            case (edit_param)
                PPS_PAR_PASSWORD: begin
                    if (!locked) begin
                        pw_d        = edit_value;
                        param_adv_d = 1'b1;
                    end else if (edit_value == pw_q) begin
                        unlock_d    = 1'b1;
                        param_adv_d = 1'b1;
                    end else begin
                        wr_reject_d = 1'b1;
                    end
                end
                PPS_PAR_TUNE_SEL: begin
                    if (locked || tuning_guard_param) begin
                        wr_reject_d = 1'b1;
                    end else begin
                        param_wr_d      = 1'b1;
                        param_adv_d     = 1'b1;
                        param_wr_data_d = edit_value;
                        tune_d          = (edit_value == `PPS_TUNE_SEL);
                    end
                end
                default: begin
                    if (locked) begin
                        wr_reject_d = 1'b1;
                    end else begin
                        param_wr_d      = 1'b1;
                        param_adv_d     = 1'b1;
                        param_wr_data_d = edit_value;
                    end
                end
            endcase
        end
        if (tune_done) begin
            tune_d = 1'b0;
        end
        if (prog_exit) begin
            unlock_d = 1'b0;
        end
        lock_mark_d = menu_level2 && locked;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pw_q            <= `PPS_PW_NONE;
            unlock_q        <= 1'b0;
            tune_q          <= 1'b0;
            blink_q         <= 1'b0;
            blink_cnt_q     <= 32'h0;
            param_wr_q      <= 1'b0;
            param_adv_q     <= 1'b0;
            wr_reject_q     <= 1'b0;
            param_wr_data_q <= 16'h0;
            lock_mark_q     <= 1'b0;
        end else begin
            pw_q            <= pw_d;
            unlock_q        <= unlock_d;
            tune_q          <= tune_d;
            blink_q         <= blink_d;
            blink_cnt_q     <= blink_cnt_d;
            param_wr_q      <= param_wr_d;
            param_adv_q     <= param_adv_d;
            wr_reject_q     <= wr_reject_d;
            param_wr_data_q <= param_wr_data_d;
            lock_mark_q     <= lock_mark_d;
        end
    end

    // ****************************************
    // self-test sequencer
    // ****************************************
    pps_st_t     st_d;
    logic [31:0] tmr_q, tmr_d;
    logic        both_q, both_d, tick;
    logic [2:0]  unit_d;
    logic [7:0]  lcd_d, addr_d, wdata_d;
    logic        lo_d, hi_d, we_d, re_d, fail_d, tune_mark_d, busy_d;

    function automatic logic [7:0] pattern(input logic [7:0] a);
        pattern = a ^ `PPS_MEM_PATTERN;
    endfunction : pattern

    // the lcd sweep paces on its own, shorter column time
    assign tick = (tmr_q >= ((st_q == PPS_ST_LCD) ? COL_CYC : STEP_CYC) - 32'h1);

    always_comb begin
        st_d        = st_q;
        tmr_d       = tick ? 32'h0 : tmr_q + 32'h1;
        both_d      = keys.menu_escape_key && keys.halt_clear_key;
        unit_d      = unit_led_q;
        lcd_d       = lcd_dark_q;
        lo_d        = 1'b0;
        hi_d        = 1'b0;
        addr_d      = mem_addr_q;
        wdata_d     = mem_wdata_q;
        we_d        = 1'b0;
        re_d        = 1'b0;
        fail_d      = selftest_fail_q;
        tune_mark_d = tune_q;
        case (st_q)
            PPS_ST_IDLE: begin
                tmr_d  = 32'h0;
                lcd_d  = 8'h0;
                unit_d = tune_q ? (blink_q ? `PPS_UNITS_ALL : `PPS_UNITS_OFF)
                                : `PPS_UNITS_OFF;
                // only a fresh press of both keys while stopped
                if (both_d && !both_q && drive_stopped) begin
                    st_d   = PPS_ST_DIGIT_LO;
                    fail_d = 1'b0;
                end
            end
            PPS_ST_DIGIT_LO: begin
                if (tick) begin
                    st_d = PPS_ST_DIGIT_HI;
                end
            end
            PPS_ST_DIGIT_HI: begin
                if (tick) begin
                    st_d   = PPS_ST_UNITS;
                    unit_d = `PPS_UNITS_FIRST;
                end
            end
            PPS_ST_UNITS: begin
                if (tick) begin
                    if (unit_led_q == `PPS_UNITS_ALL) begin
                        st_d = PPS_ST_LCD;
                    end else begin
                        unit_d = {unit_led_q[1:0], 1'b1};
                    end
                end
            end
            PPS_ST_LCD: begin
                unit_d = `PPS_UNITS_OFF;
                if (tick) begin
                    if (lcd_dark_q != `PPS_LCD_COLS) begin
                        lcd_d = lcd_dark_q + 8'h1;
                    end else if (nv_data_valid) begin
                        st_d = PPS_ST_IDLE;
                    end else begin
                        st_d    = PPS_ST_MEM_WR;
                        addr_d  = 8'h0;
                        wdata_d = pattern(8'h0);
                        we_d    = 1'b1;
                    end
                end
            end
            PPS_ST_MEM_WR: begin
                if (mem_addr_q == `PPS_MEM_LAST) begin
                    st_d   = PPS_ST_MEM_RD;
                    addr_d = 8'h0;
                    re_d   = 1'b1;
                end else begin
                    addr_d  = mem_addr_q + 8'h1;
                    wdata_d = pattern(addr_d);
                    we_d    = 1'b1;
                end
            end
            PPS_ST_MEM_RD: begin
                st_d = PPS_ST_MEM_CHK;
            end
            PPS_ST_MEM_CHK: begin
                if (mem_rdata != pattern(mem_addr_q)) begin
                    fail_d = 1'b1;
                end
                if (mem_addr_q == `PPS_MEM_LAST) begin
                    st_d = PPS_ST_IDLE;
                end else begin
                    st_d   = PPS_ST_MEM_RD;
                    addr_d = mem_addr_q + 8'h1;
                    re_d   = 1'b1;
                end
            end
            default: begin
                st_d = PPS_ST_IDLE;
            end
        endcase
        // phase outputs follow the next state so they line up with busy
        lo_d   = (st_d == PPS_ST_DIGIT_LO);
        hi_d   = (st_d == PPS_ST_DIGIT_HI);
        busy_d = (st_d != PPS_ST_IDLE);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q            <= PPS_ST_IDLE;
            tmr_q           <= 32'h0;
            both_q          <= 1'b0;
            unit_led_q      <= `PPS_UNITS_OFF;
            lcd_dark_q      <= 8'h0;
            digit_lo_q      <= 1'b0;
            digit_hi_q      <= 1'b0;
            mem_addr_q      <= 8'h0;
            mem_wdata_q     <= 8'h0;
            mem_we_q        <= 1'b0;
            mem_re_q        <= 1'b0;
            selftest_fail_q <= 1'b0;
            selftest_busy_q <= 1'b0;
            tune_mark_q     <= 1'b0;
        end else begin
            st_q            <= st_d;
            tmr_q           <= tmr_d;
            both_q          <= both_d;
            unit_led_q      <= unit_d;
            lcd_dark_q      <= lcd_d;
            digit_lo_q      <= lo_d;
            digit_hi_q      <= hi_d;
            mem_addr_q      <= addr_d;
            mem_wdata_q     <= wdata_d;
            mem_we_q        <= we_d;
            mem_re_q        <= re_d;
            selftest_fail_q <= fail_d;
            selftest_busy_q <= busy_d;
            tune_mark_q     <= tune_mark_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_zero_no_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (save_ok && edit_param == PPS_PAR_OTHER && pw_q == `PPS_PW_NONE) |=> param_wr_q)
        else $error("write refused with no password");
    a_match_unlocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (save_ok && edit_param == PPS_PAR_PASSWORD && locked && edit_value == pw_q
         && !prog_exit) |=> (unlock_q && !wr_reject_q))
        else $error("matching code did not unlock");
    a_locked_rejects: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (save_ok && edit_param == PPS_PAR_OTHER && locked) |=> (wr_reject_q && !param_wr_q))
        else $error("locked write was accepted");
    a_lock_mark_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (menu_level2 && pw_q != `PPS_PW_NONE && !unlock_q) |=> lock_mark_q)
        else $error("lock mark missing");
    a_exit_relocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
        prog_exit |=> !unlock_q)
        else $error("lock not re-armed on exit");
    a_zero_cancels: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (save_ok && edit_param == PPS_PAR_PASSWORD && unlock_q && edit_value == `PPS_PW_NONE)
        |=> (pw_q == `PPS_PW_NONE))
        else $error("password not cancelled");
    a_guard_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (save_ok && edit_param == PPS_PAR_TUNE_SEL && tuning_guard_param && !tune_q)
        |=> (!tune_q && wr_reject_q))
        else $error("tuning entered against guard");
    a_tune_flash: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (tune_q && st_q == PPS_ST_IDLE) |=> (tune_mark_q && (unit_led_q == `PPS_UNITS_ALL
                                      || unit_led_q == `PPS_UNITS_OFF)))
        else $error("tuning display wrong");
    a_start_stopped: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == PPS_ST_IDLE && !drive_stopped) |=> (st_q == PPS_ST_IDLE))
        else $error("self-test started while running");
    a_skip_memory: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_q == PPS_ST_LCD && nv_data_valid) |=> !mem_we_q)
        else $error("memory written while holding data");
    a_fail_keeps_pw: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (save_ok && edit_param == PPS_PAR_PASSWORD && locked && edit_value != pw_q)
        |=> ($stable(pw_q) && !param_wr_q))
        else $error("failed compare changed state");
endmodule : pps_panel
`default_nettype wire

// [dv/pps_mem_model.sv]
// keypad nonvolatile memory model answering the panel's strobes
`timescale 1ns/1ps
`default_nettype none
module pps_mem_model (
    // clock
    input  wire logic       clk_sys,
    // memory strobes
    input  wire logic [7:0] mem_addr,
    input  wire logic [7:0] mem_wdata,
    input  wire logic       mem_we,
    input  wire logic       mem_re,
    // fault injection, flips bit 0 of every read
    input  wire logic       corrupt,
    // read answer
    output logic [7:0]      mem_rdata
);
    logic [7:0] cell_q [256];

    initial mem_rdata = 8'h00;

    always @(posedge clk_sys) begin
        if (mem_we) begin
            cell_q[mem_addr] <= mem_wdata;
        end
        // outside the answer cycle the bus flips, so a stale value never matches
        if (mem_re) begin
            mem_rdata <= cell_q[mem_addr] ^ {7'h00, corrupt};
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : pps_mem_model
`default_nettype wire

// [dv/pps_panel_tb.sv]
// self-checking bench for the panel password, tuning and self-test block
`timescale 1ns/1ps
`default_nettype none
module pps_panel_tb;
    import pps_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [31:0] STEP = 32'h8;
    localparam logic [31:0] COL  = 32'h2;
    logic       clk_sys = 1'b0, rst_n, menu_key, halt_key, edit_valid, edit_save, menu_level2;
    logic       prog_exit, drive_stopped, guard, tune_done, nv_valid, bad_mem;
    pps_param_t edit_param;
    logic [15:0] edit_value, param_wr_data_q, secret;
    logic [7:0] mem_addr_q, mem_wdata_q, mem_rdata, lcd_dark_q;
    logic       mem_we_q, mem_re_q, param_wr_q, param_adv_q, wr_reject_q, lock_mark_q;
    logic       tune_mark_q, digit_lo_q, digit_hi_q, selftest_busy_q, selftest_fail_q;
    logic [2:0] unit_led_q;
    int         errors, checks, cyc, pw, unlocked, tuning;

    pps_panel #(.STEP_CYC(STEP), .COL_CYC(COL)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .menu_escape_key_pin(menu_key),
        .halt_clear_key_pin(halt_key), .edit_valid(edit_valid), .edit_param(edit_param),
        .edit_value(edit_value), .edit_save(edit_save), .menu_level2(menu_level2),
        .prog_exit(prog_exit), .drive_stopped(drive_stopped), .tuning_guard_param(guard),
        .tune_done(tune_done), .nv_data_valid(nv_valid), .mem_addr_q(mem_addr_q),
        .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q), .mem_re_q(mem_re_q),
        .mem_rdata(mem_rdata), .param_wr_q(param_wr_q), .param_wr_data_q(param_wr_data_q),
        .param_adv_q(param_adv_q), .wr_reject_q(wr_reject_q), .lock_mark_q(lock_mark_q),
        .tune_mark_q(tune_mark_q), .unit_led_q(unit_led_q), .digit_lo_q(digit_lo_q),
        .digit_hi_q(digit_hi_q), .lcd_dark_q(lcd_dark_q), .selftest_busy_q(selftest_busy_q),
        .selftest_fail_q(selftest_fail_q));

    pps_mem_model mem_u (.clk_sys(clk_sys), .mem_addr(mem_addr_q), .mem_wdata(mem_wdata_q),
        .mem_we(mem_we_q), .mem_re(mem_re_q), .corrupt(bad_mem), .mem_rdata(mem_rdata));

    always #2 clk_sys = ~clk_sys;

    // hang guard, far above the longest self-test
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic end_sim();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input int exp);
        checks++;
        if (got !== exp[15:0]) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp[15:0]);
        end
    endtask : chk

    task automatic chk_lock();
        repeat (2) @(negedge clk_sys);
        chk(lock_mark_q, (pw != 0) && (unlocked == 0));
    endtask : chk_lock

    // reference answer worked out before the edit is presented
    task automatic edit(input pps_param_t p, input logic [15:0] v, input logic save);
        int lk, e_wr, e_adv, e_rej;
        lk = (pw != 0) && (unlocked == 0);
        e_wr = 0;
        e_adv = 0;
        e_rej = 0;
        if (save && p == PPS_PAR_PASSWORD) begin
            e_adv = !lk || (v == pw[15:0]);
            e_rej = !e_adv;
            if (!lk) begin
                pw = v;
            end else if (e_adv) begin
                unlocked = 1;
            end
        end else if (save) begin
            e_rej = lk || (p == PPS_PAR_TUNE_SEL && guard);
            e_wr = !e_rej;
            e_adv = !e_rej;
            if (e_wr && p == PPS_PAR_TUNE_SEL) begin
                tuning = (v == 16'h0002);
            end
        end
        @(negedge clk_sys);
        edit_valid = 1'b1;
        edit_param = p;
        edit_value = v;
        edit_save = save;
        @(negedge clk_sys);
        edit_valid = 1'b0;
        chk({param_adv_q, wr_reject_q}, {e_adv[0], e_rej[0]});
        if (p != PPS_PAR_PASSWORD) begin
            chk(param_wr_q, e_wr);
        end
        if (e_wr) begin
            chk(param_wr_data_q, v);
        end
    endtask : edit

    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask : pulse

    task automatic selftest(input logic nv, input logic bad);
        int n, nlo, nhi, n1, n3, n7, nwe, nre, lmax;
        {nlo, nhi, n1, n3, n7, nwe, nre, lmax} = '0;
        nv_valid = nv;
        bad_mem = bad;
        drive_stopped = 1'b1;
        @(negedge clk_sys);
        menu_key = 1'b1;
        halt_key = 1'b1;
        n = 0;
        while (selftest_busy_q !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        chk(digit_lo_q, 1);
        menu_key = 1'b0;
        halt_key = 1'b0;
        n = 0;
        while (selftest_busy_q === 1'b1 && n < 3000) begin
            nlo += digit_lo_q;
            nhi += digit_hi_q;
            n1 += (unit_led_q === 3'h1);
            n3 += (unit_led_q === 3'h3);
            n7 += (unit_led_q === 3'h7);
            nre += mem_re_q;
            lmax = (lcd_dark_q > lmax) ? lcd_dark_q : lmax;
            if (mem_we_q) begin
                nwe++;
                chk(mem_wdata_q, mem_addr_q ^ 8'hA5);
            end
            @(negedge clk_sys);
            n++;
        end
        chk(nlo, STEP);
        chk(nhi, STEP);
        chk({n1 == STEP, n3 == STEP, n7 >= STEP}, 7);
        chk(lmax, 128);
        chk(nwe, nv ? 0 : 256);
        chk(nre, nv ? 0 : 256);
        chk(selftest_fail_q, bad);
    endtask : selftest
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        int n7;
        {rst_n, menu_key, halt_key, edit_valid, edit_save} = '0;
        {prog_exit, guard, tune_done, nv_valid, bad_mem} = '0;
        menu_level2 = 1'b1;
        drive_stopped = 1'b1;
        edit_param = PPS_PAR_OTHER;
        edit_value = 16'h0000;
        {errors, checks, pw, unlocked, tuning} = '0;
        void'($urandom(93150));
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        chk_lock();
        edit(PPS_PAR_OTHER, 16'($urandom), 1'b1);
        edit(PPS_PAR_OTHER, 16'h1234, 1'b0);
        secret = 16'($urandom) | 16'h0001;
        edit(PPS_PAR_PASSWORD, secret, 1'b1);
        pulse(prog_exit);
        unlocked = 0;
        chk_lock();
        edit(PPS_PAR_OTHER, 16'($urandom), 1'b1);
        edit(PPS_PAR_PASSWORD, secret ^ 16'h0100, 1'b1);
        chk_lock();
        edit(PPS_PAR_PASSWORD, secret, 1'b1);
        chk_lock();
        edit(PPS_PAR_OTHER, 16'($urandom), 1'b1);
        pulse(prog_exit);
        unlocked = 0;
        edit(PPS_PAR_OTHER, 16'($urandom), 1'b1);
        edit(PPS_PAR_PASSWORD, secret, 1'b1);
        edit(PPS_PAR_PASSWORD, 16'h0000, 1'b1);
        pulse(prog_exit);
        unlocked = 0;
        chk_lock();
        edit(PPS_PAR_OTHER, 16'($urandom), 1'b1);
        guard = 1'b1;
        edit(PPS_PAR_TUNE_SEL, 16'h0002, 1'b1);
        chk(tune_mark_q, tuning);
        guard = 1'b0;
        edit(PPS_PAR_TUNE_SEL, 16'h0002, 1'b1);
        @(negedge clk_sys);
        chk(tune_mark_q, tuning);
        n7 = 0;
        repeat (2 * STEP) begin
            @(negedge clk_sys);
            n7 += (unit_led_q === 3'h7) ? 1 : (unit_led_q === 3'h0) ? 0 : 100;
        end
        chk(n7, STEP);
        pulse(tune_done);
        tuning = 0;
        @(negedge clk_sys);
        chk(tune_mark_q, tuning);
        drive_stopped = 1'b0;
        menu_key = 1'b1;
        halt_key = 1'b1;
        repeat (20) @(negedge clk_sys);
        chk(selftest_busy_q, 0);
        menu_key = 1'b0;
        halt_key = 1'b0;
        repeat (8) @(negedge clk_sys);
        selftest(1'b1, 1'b0);
        selftest(1'b0, 1'b1);
        selftest(1'b0, 1'b0);
        end_sim();
    end
endmodule : pps_panel_tb
`default_nettype wire
